// [verilog/fsm_consts.svh]
// Constants of the meter fault status monitor: register indices, status bits, ranges and timing.
// Assumes inclusion by the monitor and its package users only.
`ifndef FSM_CONSTS_SVH
`define FSM_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FSM_CLK_HZ 64'd50000000
`define FSM_OVER_TIME_S 64'd3600
`define FSM_OVER_CYC (`FSM_OVER_TIME_S * `FSM_CLK_HZ)
`define FSM_BLINK_TIME_MS 64'd500
`define FSM_BLINK_CYC (`FSM_BLINK_TIME_MS * `FSM_CLK_HZ / 64'd1000)

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define FSM_B_SUPPLY 0
`define FSM_B_LOWBAT 1
`define FSM_B_IN_HI 3
`define FSM_B_OUT_HI 4
`define FSM_B_IN_LO 5
`define FSM_B_OUT_LO 6
`define FSM_B_DT 7
`define FSM_B_AIR 8
`define FSM_B_REV 9
`define FSM_B_OVER 11

// ----------------------------------------------------------------
// Ranges, reset values and codes
// ----------------------------------------------------------------
`define FSM_TEMP_MIN 16'sh0000
`define FSM_TEMP_MAX 16'sh4844
`define FSM_CUTOFF_MAX 8'hfa
`define FSM_CUTOFF_RST 8'h00
`define FSM_SEL_RST 4'h0
`define FSM_SEL_STATUS 4'h1
`define FSM_LOG_DEPTH 50

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FSM_A_STATUS 3'h0
`define FSM_A_DISP_SEL 3'h1
`define FSM_A_CUTOFF 3'h2
`define FSM_A_EVCOUNT 3'h3
`define FSM_A_LOG_CURSOR 3'h4
`define FSM_A_LOG_DATA 3'h5
`define FSM_A_MODE 3'h6

`endif

// [verilog/fsm_pkg.sv]
// Types of the meter fault status monitor.
// Assumes the constants header is compiled alongside.
package fsm_pkg;

  typedef logic [11:0] fsm_word_t;

  typedef enum logic [1:0] {
    FSM_TRANSPORT = 2'b01,
    FSM_ACTIVE = 2'b10
  } fsm_mode_e;

endpackage : fsm_pkg

// [verilog/fsm_monitor.sv]
// Fault status word, fault indicator, event counter, change log and readout substitution.
// Assumes fault pins are asynchronous, measurement buses and date come from logic on clk.
//
// Function
// - Bit 3 and bit 4 flag inlet and outlet sensor above range or open.
// - Bit 5 and bit 6 flag inlet and outlet sensor below range or shorted.
// - Bit 7 flags an invalid inlet-minus-outlet temperature difference.
// - Bit 8 flags air in flow sensor, bit 9 reverse flow.
// - Bit 11 flags flow above maximum for over one hour; bit 10 unused.
// - Bit 0 supply loss only goes to the log; bit 1 flags low battery.
// - Several faults give the sum of their weights.
// - Indicator flashes whenever the word is nonzero and is not the selected reading.
// - Faults and indicator clear by themselves when the cause goes.
// - Indicator stops flashing while the status word is the selected reading.
// - Event counter steps by one on each change of the word outside transport state.
// - In transport state faults show but are neither counted nor logged.
// - Log keeps the latest 50 changes with dates, read as date then word.
// - First registered flow leaves transport state and enables counting and logging.
// - Out-of-range temperatures show dashes and clamp to the limits in serial readout.
// - Faulty temperature sensor dashes its reading, the difference and the power.
// - Faulty flow sensor gives zero serial flow and dashed flow.
// - Any sensor fault gives zero serial power.
// - Energy depending on a faulty sensor is not accumulated.
// - Optional difference cut-off, 0.01 to 2.50 K, stops energy and volume below it.
// - Negative difference shows negative and accumulates cooling instead of heat.
// - Wrong difference alone is no sensor fault; flow above nominal is no fault.
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`include "fsm_consts.svh"

module fsm_monitor
  import fsm_pkg::*;
#(
  parameter logic [37:0] OVER_CYCLES = 38'(`FSM_OVER_CYC),
  parameter logic [24:0] BLINK_CYCLES = 25'(`FSM_BLINK_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Fault pins from the sensors and supply
  input wire logic low_battery,
  input wire logic supply_lost,
  input wire logic dt_invalid,
  input wire logic flow_air,
  input wire logic flow_reverse,
  input wire logic flow_over_max,
  input wire logic flow_detected,
  // Measurements and date
  input wire logic signed [15:0] inlet_temperature,
  input wire logic signed [15:0] outlet_temperature,
  input wire logic [23:0] flow_sensor_channel,
  input wire logic [23:0] power_in,
  input wire logic [31:0] date_now,
  // Serial readout values
  output logic signed [15:0] inlet_serial,
  output logic signed [15:0] outlet_serial,
  output logic [23:0] flow_serial,
  output logic [23:0] power_serial,
  output logic signed [16:0] temp_diff,
  // Display dashes and indicator
  output logic inlet_dash,
  output logic outlet_dash,
  output logic diff_dash,
  output logic flow_dash,
  output logic power_dash,
  output logic fault_indicator,
  // Accumulation enables
  output logic heat_accum_en,
  output logic cool_accum_en,
  output logic volume_accum_en
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] sync1_q, sync2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {flow_detected, flow_over_max, flow_reverse, flow_air, dt_invalid, supply_lost, low_battery};
      sync2_q <= sync1_q;
    end
  end
  logic s_lowbat, s_supply, s_dt, s_air, s_rev, s_over, s_flow;
  assign {s_flow, s_over, s_rev, s_air, s_dt, s_supply, s_lowbat} = sync2_q;

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic in_hi, in_lo, out_hi, out_lo, temp_fault, flow_fault;
  logic [37:0] over_cnt_q, over_cnt_d;
  fsm_word_t word_q, word_d;

  assign in_hi = inlet_temperature > `FSM_TEMP_MAX;
  assign in_lo = inlet_temperature < `FSM_TEMP_MIN;
  assign out_hi = outlet_temperature > `FSM_TEMP_MAX;
  assign out_lo = outlet_temperature < `FSM_TEMP_MIN;
  // A wrong difference by itself does not count as a sensor fault.
  assign temp_fault = in_hi | in_lo | out_hi | out_lo;
  assign flow_fault = s_air | s_rev;

  always_comb begin
    over_cnt_d = over_cnt_q;
    if (!s_over) begin
      over_cnt_d = 38'h0;
    end else if (over_cnt_q < OVER_CYCLES) begin
      over_cnt_d = over_cnt_q + 38'h1;
    end
    // Each bit follows its cause directly, so all clear with no acknowledge.
    word_d = 12'h000;
    word_d[`FSM_B_LOWBAT] = s_lowbat;
    word_d[`FSM_B_IN_HI] = in_hi;
    word_d[`FSM_B_OUT_HI] = out_hi;
    word_d[`FSM_B_IN_LO] = in_lo;
    word_d[`FSM_B_OUT_LO] = out_lo;
    word_d[`FSM_B_DT] = s_dt;
    word_d[`FSM_B_AIR] = s_air;
    word_d[`FSM_B_REV] = s_rev;
    word_d[`FSM_B_OVER] = over_cnt_q == OVER_CYCLES;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      over_cnt_q <= 38'h0;
      word_q <= 12'h000;
    end else begin
      over_cnt_q <= over_cnt_d;
      word_q <= word_d;
    end
  end

  // ----------------------------------------------------------------
  // Transport state, event counter and change log
  // ----------------------------------------------------------------
  fsm_mode_e mode_q, mode_d;
  logic [31:0] evcnt_q, evcnt_d;
  logic supply_prev_q;
  logic [5:0] wp_q, wp_d, fill_q, fill_d, age_q, age_d;
  logic half_q, half_d, log_we;
  logic [31:0] log_date [`FSM_LOG_DEPTH];
  fsm_word_t log_word [`FSM_LOG_DEPTH];
  fsm_word_t log_entry;
  logic [6:0] rd_sum;
  logic [5:0] rd_idx;
  logic ack, rd_ack, wr_ack;
  logic [3:0] sel_q, sel_d;
  logic [7:0] cutoff_q, cutoff_d;

  assign ack = (avs_read | avs_write) & ~avs_waitrequest;
  assign rd_ack = ack & avs_read;
  assign wr_ack = ack & avs_write;
  assign rd_sum = 7'd`FSM_LOG_DEPTH + {1'b0, wp_q} - 7'd1 - {1'b0, age_q};
  assign rd_idx = rd_sum >= 7'd`FSM_LOG_DEPTH ? 6'(rd_sum - 7'd`FSM_LOG_DEPTH) : rd_sum[5:0];

  always_comb begin
    mode_d = mode_q;
    evcnt_d = evcnt_q;
    wp_d = wp_q;
    fill_d = fill_q;
    age_d = age_q;
    half_d = half_q;
    log_we = 1'b0;
    // Supply loss never enters the live word but is recorded with the entry.
    log_entry = word_d;
    log_entry[`FSM_B_SUPPLY] = s_supply & ~supply_prev_q;
    if (mode_q == FSM_TRANSPORT && s_flow) begin
      mode_d = FSM_ACTIVE;
    end
    if (mode_q == FSM_ACTIVE) begin
      if (word_d != word_q) begin
        evcnt_d = evcnt_q + 32'h1;
      end
      log_we = (word_d != word_q) | log_entry[`FSM_B_SUPPLY];
    end
    if (log_we) begin
      wp_d = wp_q == 6'(`FSM_LOG_DEPTH - 1) ? 6'h0 : wp_q + 6'h1;
      fill_d = fill_q == 6'(`FSM_LOG_DEPTH) ? fill_q : fill_q + 6'h1;
    end
    if (wr_ack && avs_address == `FSM_A_LOG_CURSOR) begin
      age_d = 6'h0;
      half_d = 1'b0;
    end else if (rd_ack && avs_address == `FSM_A_LOG_DATA) begin
      // Date first, then its word, then on to the next older entry.
      half_d = ~half_q;
      if (half_q) begin
        age_d = (age_q + 6'h1 >= fill_q) ? 6'h0 : age_q + 6'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= FSM_TRANSPORT;
      evcnt_q <= 32'h0;
      supply_prev_q <= 1'b0;
      wp_q <= 6'h0;
      fill_q <= 6'h0;
      age_q <= 6'h0;
      half_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      evcnt_q <= evcnt_d;
      supply_prev_q <= s_supply;
      wp_q <= wp_d;
      fill_q <= fill_d;
      age_q <= age_d;
      half_q <= half_d;
    end
  end

  // The log array carries no reset; only entries below the fill level are ever read.
  always_ff @(posedge clk) begin
    if (log_we) begin
      log_date[wp_q] <= date_now;
      log_word[wp_q] <= log_entry;
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic ws_q, ws_d;
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    ws_d = 1'b1;
    rdata_d = rdata_q;
    sel_d = sel_q;
    cutoff_d = cutoff_q;
    if ((avs_read | avs_write) && ws_q) begin
      ws_d = 1'b0;
      rdata_d = 32'h0;
      if (avs_read) begin
        case (avs_address)
          `FSM_A_STATUS: rdata_d = {20'h0, word_q};
          `FSM_A_DISP_SEL: rdata_d = {28'h0, sel_q};
          `FSM_A_CUTOFF: rdata_d = {24'h0, cutoff_q};
          `FSM_A_EVCOUNT: rdata_d = evcnt_q;
          `FSM_A_LOG_CURSOR: rdata_d = {26'h0, fill_q};
          `FSM_A_LOG_DATA: rdata_d = fill_q == 6'h0 ? 32'h0 : half_q ? {20'h0, log_word[rd_idx]} : log_date[rd_idx];
          `FSM_A_MODE: rdata_d = {31'h0, mode_q == FSM_TRANSPORT};
          default: rdata_d = 32'h0;
        endcase
      end
    end
    if (wr_ack && avs_address == `FSM_A_DISP_SEL) begin
      sel_d = avs_writedata[3:0];
    end
    // Cut-off values beyond 2.50 K are refused and leave the old setting.
    if (wr_ack && avs_address == `FSM_A_CUTOFF && avs_writedata[31:0] <= 32'(`FSM_CUTOFF_MAX)) begin
      cutoff_d = avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ws_q <= 1'b1;
      rdata_q <= 32'h0;
      sel_q <= `FSM_SEL_RST;
      cutoff_q <= `FSM_CUTOFF_RST;
    end else begin
      ws_q <= ws_d;
      rdata_q <= rdata_d;
      sel_q <= sel_d;
      cutoff_q <= cutoff_d;
    end
  end
  assign avs_waitrequest = ws_q;
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // Indicator, readout substitution and accumulation
  // ----------------------------------------------------------------
  logic [24:0] blink_cnt_q, blink_cnt_d;
  logic blink_q, blink_d, ind_q, ind_d;
  logic signed [15:0] in_ser_q, in_ser_d, out_ser_q, out_ser_d;
  logic [23:0] flow_ser_q, flow_ser_d, pow_ser_q, pow_ser_d;
  logic signed [16:0] diff_q, diff_d, diff_mag;
  logic [4:0] dash_q, dash_d;
  logic [2:0] acc_q, acc_d;
  logic below_cut;

  assign diff_mag = diff_d < 0 ? -diff_d : diff_d;
  assign below_cut = cutoff_q != 8'h00 && diff_mag < $signed({9'h0, cutoff_q});

  always_comb begin
    blink_cnt_d = blink_cnt_q + 25'h1;
    blink_d = blink_q;
    if (blink_cnt_q >= BLINK_CYCLES - 25'h1) begin
      blink_cnt_d = 25'h0;
      blink_d = ~blink_q;
    end
    // Held steady while the word itself is on view, so the reading is not hidden.
    if (word_q == 12'h000) begin
      ind_d = 1'b0;
    end else if (sel_q == `FSM_SEL_STATUS) begin
      ind_d = 1'b1;
    end else begin
      ind_d = blink_q;
    end
    in_ser_d = in_hi ? `FSM_TEMP_MAX : in_lo ? `FSM_TEMP_MIN : inlet_temperature;
    out_ser_d = out_hi ? `FSM_TEMP_MAX : out_lo ? `FSM_TEMP_MIN : outlet_temperature;
    flow_ser_d = flow_fault ? 24'h0 : flow_sensor_channel;
    pow_ser_d = (flow_fault | temp_fault) ? 24'h0 : power_in;
    diff_d = $signed({inlet_temperature[15], inlet_temperature}) - $signed({outlet_temperature[15], outlet_temperature});
    dash_d = {flow_fault | temp_fault, flow_fault, temp_fault, out_hi | out_lo, in_hi | in_lo};
    acc_d[0] = ~temp_fault & ~flow_fault & ~below_cut & diff_d > 0;
    acc_d[1] = ~temp_fault & ~flow_fault & ~below_cut & diff_d < 0;
    acc_d[2] = ~flow_fault & ~below_cut;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      blink_cnt_q <= 25'h0;
      blink_q <= 1'b0;
      ind_q <= 1'b0;
      in_ser_q <= 16'sh0000;
      out_ser_q <= 16'sh0000;
      flow_ser_q <= 24'h0;
      pow_ser_q <= 24'h0;
      diff_q <= 17'sh00000;
      dash_q <= 5'h00;
      acc_q <= 3'h0;
    end else begin
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
      ind_q <= ind_d;
      in_ser_q <= in_ser_d;
      out_ser_q <= out_ser_d;
      flow_ser_q <= flow_ser_d;
      pow_ser_q <= pow_ser_d;
      diff_q <= diff_d;
      dash_q <= dash_d;
      acc_q <= acc_d;
    end
  end

  assign fault_indicator = ind_q;
  assign inlet_serial = in_ser_q;
  assign outlet_serial = out_ser_q;
  assign flow_serial = flow_ser_q;
  assign power_serial = pow_ser_q;
  assign temp_diff = diff_q;
  assign {power_dash, flow_dash, diff_dash, outlet_dash, inlet_dash} = dash_q;
  assign {volume_accum_en, cool_accum_en, heat_accum_en} = acc_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_word_unused_zero: assert property (@(posedge clk) disable iff (!nrst)
    word_q[`FSM_B_SUPPLY] == 1'b0 && word_q[2] == 1'b0 && word_q[10] == 1'b0)
    else $error("Unused or supply bit set in live word.");
  a_word_inlet_low: assert property (@(posedge clk) disable iff (!nrst)
    inlet_temperature < `FSM_TEMP_MIN |=> word_q[`FSM_B_IN_LO] && !word_q[`FSM_B_IN_HI])
    else $error("Inlet below range not flagged.");
  a_ind_steady: assert property (@(posedge clk) disable iff (!nrst)
    (word_q != 12'h000 && sel_q == `FSM_SEL_STATUS) [*2] |=> fault_indicator)
    else $error("Indicator not steady while word selected.");
  a_ind_clear: assert property (@(posedge clk) disable iff (!nrst)
    word_q == 12'h000 |=> !fault_indicator)
    else $error("Indicator on with clear word.");
  a_count_step: assert property (@(posedge clk) disable iff (!nrst)
    (mode_q == FSM_ACTIVE && word_d != word_q) |=> evcnt_q == $past(evcnt_q) + 32'h1)
    else $error("Event counter did not step.");
  a_transport_hold: assert property (@(posedge clk) disable iff (!nrst)
    mode_q == FSM_TRANSPORT |=> evcnt_q == $past(evcnt_q) && wp_q == $past(wp_q))
    else $error("Counted or logged in transport state.");
  a_transport_exit: assert property (@(posedge clk) disable iff (!nrst)
    (mode_q == FSM_TRANSPORT && s_flow) |=> mode_q == FSM_ACTIVE)
    else $error("Flow did not end transport state.");
  a_clamp_high: assert property (@(posedge clk) disable iff (!nrst)
    inlet_temperature > `FSM_TEMP_MAX |=> inlet_serial == `FSM_TEMP_MAX && inlet_dash)
    else $error("High inlet not clamped.");
  a_power_zero: assert property (@(posedge clk) disable iff (!nrst)
    (flow_fault || temp_fault) |=> power_serial == 24'h0 && power_dash)
    else $error("Power not zero during fault.");
  a_accum_block: assert property (@(posedge clk) disable iff (!nrst)
    (temp_fault || flow_fault) |=> !heat_accum_en && !cool_accum_en)
    else $error("Energy accumulates during fault.");
  a_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not in one cycle.");

endmodule : fsm_monitor

// [bench/fsm_sensor_model.sv]
// Sensor side of the fault status monitor: temperature pair, flow sensor, supply and calendar.
// Assumes the bench commands levels and values; they reach the pins one clock later.
`timescale 1ns/1ns

module fsm_sensor_model (
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic [6:0] cmd_pins,
  input wire logic signed [15:0] cmd_t_in,
  input wire logic signed [15:0] cmd_t_out,
  input wire logic [23:0] cmd_flow,
  input wire logic [31:0] cmd_date,
  // Fault pins
  output logic low_battery,
  output logic supply_lost,
  output logic dt_invalid,
  output logic flow_air,
  output logic flow_reverse,
  output logic flow_over_max,
  output logic flow_detected,
  // Measurements and date
  output logic signed [15:0] inlet_temperature,
  output logic signed [15:0] outlet_temperature,
  output logic [23:0] flow_sensor_channel,
  output logic [23:0] power_in,
  output logic [31:0] date_now
);
  // ----------------------------------------------------------------
  // Converters
  // ----------------------------------------------------------------
  // One register stage stands for the converters, so values change only just after an edge.
  always_ff @(posedge clk) begin
    {flow_detected, flow_over_max, flow_reverse, flow_air} <= cmd_pins[6:3];
    {dt_invalid, supply_lost, low_battery} <= cmd_pins[2:0];
    inlet_temperature <= cmd_t_in;
    outlet_temperature <= cmd_t_out;
    flow_sensor_channel <= cmd_flow;
    power_in <= 24'h000123;
    date_now <= cmd_date;
  end
endmodule : fsm_sensor_model

// [bench/fsm_monitor_tb.sv]
// Self-checking bench of the fault status monitor, driven over its register bus.
// Assumes the sensor model on the far side and short hour and blink counts.
`timescale 1ns/1ns
`include "fsm_consts.svh"

module fsm_monitor_tb;
  import fsm_pkg::*;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, date_now, rd, cmd_date;
  logic low_battery, supply_lost, dt_invalid, flow_air, flow_reverse, flow_over_max, flow_detected;
  logic signed [15:0] inlet_temperature, outlet_temperature, inlet_serial, outlet_serial, cmd_t_in, cmd_t_out;
  logic [23:0] flow_sensor_channel, power_in, flow_serial, power_serial, cmd_flow;
  logic signed [16:0] temp_diff;
  logic inlet_dash, outlet_dash, diff_dash, flow_dash, power_dash, fault_indicator, a;
  logic heat_accum_en, cool_accum_en, volume_accum_en;
  logic [6:0] cmd_pins;
  int miscompares, tests_run, exp_ev, exp_fill;
  int tin[4] = '{18600, 6000, -5, 6000};
  int tout[4] = '{4000, 18501, 4000, -1};
  int tw[4] = '{8, 16, 32, 64};
  int wt[5] = '{2, 0, 128, 256, 512};
  int cin[3] = '{6000, 6000, 5800};
  int cout[3] = '{5950, 5800, 6000};
  logic [2:0] cen[3] = '{3'b000, 3'b101, 3'b011};

  fsm_monitor #(.OVER_CYCLES(38'd20), .BLINK_CYCLES(25'd4)) i_fsm_monitor (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .low_battery(low_battery), .supply_lost(supply_lost), .dt_invalid(dt_invalid), .flow_air(flow_air),
    .flow_reverse(flow_reverse), .flow_over_max(flow_over_max), .flow_detected(flow_detected),
    .inlet_temperature(inlet_temperature), .outlet_temperature(outlet_temperature),
    .flow_sensor_channel(flow_sensor_channel), .power_in(power_in), .date_now(date_now),
    .inlet_serial(inlet_serial), .outlet_serial(outlet_serial), .flow_serial(flow_serial),
    .power_serial(power_serial), .temp_diff(temp_diff), .inlet_dash(inlet_dash), .outlet_dash(outlet_dash),
    .diff_dash(diff_dash), .flow_dash(flow_dash), .power_dash(power_dash), .fault_indicator(fault_indicator),
    .heat_accum_en(heat_accum_en), .cool_accum_en(cool_accum_en), .volume_accum_en(volume_accum_en));

  fsm_sensor_model i_fsm_sensor_model (
    .clk(clk), .cmd_pins(cmd_pins), .cmd_t_in(cmd_t_in), .cmd_t_out(cmd_t_out), .cmd_flow(cmd_flow),
    .cmd_date(cmd_date), .low_battery(low_battery), .supply_lost(supply_lost), .dt_invalid(dt_invalid),
    .flow_air(flow_air), .flow_reverse(flow_reverse), .flow_over_max(flow_over_max),
    .flow_detected(flow_detected), .inlet_temperature(inlet_temperature),
    .outlet_temperature(outlet_temperature), .flow_sensor_channel(flow_sensor_channel),
    .power_in(power_in), .date_now(date_now));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // One request, held until waitrequest is seen low; a spare edge keeps strobes from being set twice.
  // Only the watchdog ends a wait that never gets its answer.
  task bus(input logic wr, input logic [2:0] ad, input logic [31:0] d);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task rd_chk(input logic [2:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  // Pins cross a model stage and a two-stage synchroniser before the word moves.
  task set_pins(input logic [6:0] p);
    cmd_pins <= p;
    repeat (6) @(posedge clk);
  endtask : set_pins

  // One edge first, so that a selection written just before has reached the indicator register.
  task blink_chk;
    @(posedge clk);
    a = fault_indicator;
    repeat (4) @(posedge clk);
    chk({31'h0, fault_indicator}, {31'h0, ~a});
  endtask : blink_chk

  task end_sim;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim;
  end

  initial begin
    nrst = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    cmd_pins = 7'h00;
    cmd_t_in = 16'sd6000;
    cmd_t_out = 16'sd4000;
    cmd_flow = 24'd1000;
    cmd_date = 32'h00010203;
    exp_ev = 0;
    exp_fill = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(`FSM_A_STATUS, 32'h0);
    rd_chk(`FSM_A_MODE, 32'h1);
    rd_chk(`FSM_A_EVCOUNT, 32'h0);
    rd_chk(3'h7, 32'h0);
    bus(1'b1, `FSM_A_STATUS, 32'hfff);
    rd_chk(`FSM_A_STATUS, 32'h0);
    $display("test reset finished");
    set_pins(7'h01);
    rd_chk(`FSM_A_STATUS, 32'h2);
    blink_chk;
    set_pins(7'h00);
    rd_chk(`FSM_A_STATUS, 32'h0);
    chk({31'h0, fault_indicator}, 32'h0);
    rd_chk(`FSM_A_EVCOUNT, 32'h0);
    rd_chk(`FSM_A_LOG_CURSOR, 32'h0);
    set_pins(7'h40);
    rd_chk(`FSM_A_MODE, 32'h0);
    $display("test transport finished");
    for (int i = 0; i < 5; i++) begin
      set_pins(7'h40 | 7'(1 << i));
      rd_chk(`FSM_A_STATUS, 32'(wt[i]));
      chk({8'h0, flow_serial}, (i == 3 || i == 4) ? 32'h0 : 32'd1000);
      set_pins(7'h40);
      rd_chk(`FSM_A_STATUS, 32'h0);
      exp_ev += (wt[i] != 0) ? 2 : 0;
      exp_fill += (wt[i] != 0) ? 2 : 1;
    end
    rd_chk(`FSM_A_EVCOUNT, 32'(exp_ev));
    for (int j = 0; j < 4; j++) begin
      cmd_t_in <= 16'(tin[j]);
      cmd_t_out <= 16'(tout[j]);
      repeat (4) @(posedge clk);
      rd_chk(`FSM_A_STATUS, 32'(tw[j]));
      chk(32'(inlet_serial), (j == 0) ? 32'd18500 : (j == 2) ? 32'h0 : 32'd6000);
      chk(32'(outlet_serial), (j == 1) ? 32'd18500 : (j == 3) ? 32'h0 : 32'd4000);
      chk({28'h0, inlet_dash, outlet_dash, diff_dash, power_dash}, {28'h0, j[0] == 0, j[0] == 1, 2'b11});
      chk({8'h0, power_serial}, 32'h0);
      chk({29'h0, heat_accum_en, cool_accum_en, volume_accum_en}, 32'h1);
      cmd_t_in <= 16'sd6000;
      cmd_t_out <= 16'sd4000;
      repeat (4) @(posedge clk);
      exp_ev += 2;
      exp_fill += 2;
    end
    cmd_t_in <= 16'sd18600;
    set_pins(7'h4c);
    rd_chk(`FSM_A_STATUS, 32'd392);
    chk({31'h0, flow_dash}, 32'h1);
    cmd_t_in <= 16'sd6000;
    set_pins(7'h40);
    // The temperature reaches the word two cycles before the pins, so each way gives two changes.
    exp_ev += 4;
    exp_fill += 4;
    $display("test fault codes finished");
    set_pins(7'h60);
    rd_chk(`FSM_A_STATUS, 32'h0);
    repeat (20) @(posedge clk);
    rd_chk(`FSM_A_STATUS, 32'd2048);
    chk({8'h0, flow_serial}, 32'd1000);
    set_pins(7'h40);
    rd_chk(`FSM_A_STATUS, 32'h0);
    set_pins(7'h41);
    bus(1'b1, `FSM_A_DISP_SEL, 32'h1);
    repeat (8) begin
      @(posedge clk);
      chk({31'h0, fault_indicator}, 32'h1);
    end
    bus(1'b1, `FSM_A_DISP_SEL, 32'h0);
    blink_chk;
    set_pins(7'h40);
    exp_ev += 4;
    exp_fill += 4;
    $display("test indicator finished");
    rd_chk(`FSM_A_LOG_CURSOR, 32'(exp_fill));
    cmd_date <= 32'h00070809;
    set_pins(7'h44);
    bus(1'b1, `FSM_A_LOG_CURSOR, 32'h0);
    rd_chk(`FSM_A_LOG_DATA, 32'h00070809);
    rd_chk(`FSM_A_LOG_DATA, 32'd128);
    rd_chk(`FSM_A_LOG_DATA, 32'h00010203);
    set_pins(7'h40);
    exp_ev += 2;
    rd_chk(`FSM_A_EVCOUNT, 32'(exp_ev));
    $display("test log finished");
    bus(1'b1, `FSM_A_CUTOFF, 32'd100);
    bus(1'b1, `FSM_A_CUTOFF, 32'd251);
    rd_chk(`FSM_A_CUTOFF, 32'd100);
    for (int k = 0; k < 3; k++) begin
      cmd_t_in <= 16'(cin[k]);
      cmd_t_out <= 16'(cout[k]);
      repeat (4) @(posedge clk);
      chk({29'h0, heat_accum_en, cool_accum_en, volume_accum_en}, {29'h0, cen[k]});
      chk(32'(temp_diff), 32'(cin[k] - cout[k]));
    end
    $display("test cut-off finished");
    end_sim;
  end
endmodule : fsm_monitor_tb
